// ---- verilog/scp_pkg.sv ----
package scp_pkg;
    // ----------------------------------------------------------------
    // device register map
    // ----------------------------------------------------------------
    localparam int NUM_REGS = 91;
    localparam logic [6:0] REG_CFG = 7'h00;
    localparam logic [6:0] REG_FUNC = 7'h58;
    localparam logic [6:0] REG_UPD = 7'h5A;
    localparam logic [12:0] REG_LAST = 13'h005A;
    localparam int CFG_BIDIR = 7;
    localparam int CFG_LSB = 6;
    localparam int CFG_SRST = 5;
    localparam int FUNC_POS = 5;
    localparam int UPD_POS = 0;
    localparam logic [1:0] FUNC_HRST = 2'h0;
    localparam logic [7:0] REG_DEFAULT = 8'h00;
    // ----------------------------------------------------------------
    // instruction word
    // ----------------------------------------------------------------
    localparam int INSTR_RW = 15;
    localparam int LEN_POS = 13;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [5:0] DATA_FIRST = 6'h10;
    localparam logic [5:0] ONE_BYTE_LAST = 6'h17;
    // ----------------------------------------------------------------
    // host side: shift clock divider and host registers
    // ----------------------------------------------------------------
    localparam logic [4:0] SCLK_HALF = 5'h08;
    localparam logic [4:0] SCLK_LAST = 5'h0F;
    localparam logic [7:0] HOST_CMD = 8'h00;
    localparam logic [7:0] HOST_WDATA = 8'h04;
    localparam logic [7:0] HOST_RDATA = 8'h08;
    localparam logic [7:0] HOST_STAT = 8'h0C;
    localparam logic [7:0] HOST_CFG = 8'h10;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [7:0] scp_byte_t;
    typedef enum logic [2:0] {
        SCP_ST_INSTR = 3'b001,
        SCP_ST_DATA = 3'b010,
        SCP_ST_DONE = 3'b100
    } scp_st_e;
    typedef enum logic [3:0] {
        SCP_H_IDLE = 4'b0001,
        SCP_H_SHIFT = 4'b0010,
        SCP_H_PAUSE = 4'b0100,
        SCP_H_GAP = 4'b1000
    } scp_hst_e;
endpackage : scp_pkg

// ---- verilog/scp_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface scp_link_if;
    logic sclk;
    logic frame_select_n;
    logic host_bidir_o;
    logic host_bidir_oe;
    logic dev_bidir_o;
    logic dev_bidir_oe;
    logic serial_out_o;
    logic serial_out_oe;
    // resolved wire levels; an undriven line reads low like the pulldown
    logic bidir_line;
    logic serial_out_line;
    assign bidir_line = dev_bidir_oe ? dev_bidir_o :
                        (host_bidir_oe ? host_bidir_o : 1'b0);
    assign serial_out_line = serial_out_oe ? serial_out_o : 1'b0;
    modport device(input sclk, input frame_select_n, input bidir_line,
                   output dev_bidir_o, output dev_bidir_oe,
                   output serial_out_o, output serial_out_oe);
    modport host(input bidir_line, input serial_out_line,
                 output sclk, output frame_select_n,
                 output host_bidir_o, output host_bidir_oe);
endinterface : scp_link_if
`default_nettype wire

// ---- verilog/scp_sync2.sv ----
`timescale 1ns/10ps
`default_nettype none
module scp_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : scp_sync2
`default_nettype wire

// ---- verilog/scp_device.sv ----
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - sample writes on rising, launch reads falling
// - default separate output line; bit 7 shares
// - serial output drives only when bit 7 clear
// - both data lines released while frame high
// - host frames every cycle with select low
// - last byte stored only on byte-aligned end
// - short transfers may pause on byte boundaries
// - pause holds state, resumes on next fall
// - abort by finishing or short partial frame
// - off-boundary raise resets port, drops data
// - streaming: unbounded bytes, ended by raise
// - sixteen-bit instruction precedes data phase
// - instruction gives direction, length, address
// - soft reset defaults all but register zero
// - soft reset holds until bit written zero
// - function pin hard reset restores defaults
// - power-on reset loads all defaults
// - instruction: direction, length code, address
// - update bit copies buffer, then self-clears
// - reads return buffer, not active registers
// - bit 6: lsb first, incrementing, immediate
module scp_device (
    input wire logic hclk,
    input wire logic hresetn,
    scp_link_if.device link,
    input wire logic hard_reset_n,
    input wire logic [6:0] act_addr,
    output scp_pkg::scp_byte_t act_data_r,
    output logic soft_reset_r,
    output logic hard_reset_r
);
    import scp_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [3:0] pin_s;
    logic sclk_s;
    logic fsel_s;
    logic sdi_s;
    logic hrst_s;
    logic sclk_d_r;
    logic fsel_d_r;
    logic rise;
    logic fall;
    logic cs_rise;

    scp_sync2 #(
        .WIDTH(4),
        .RST_VAL(4'h5)
    ) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({link.sclk, link.frame_select_n, link.bidir_line,
            hard_reset_n}),
        .q(pin_s)
    );

    assign sclk_s = pin_s[3];
    assign fsel_s = pin_s[2];
    assign sdi_s = pin_s[1];
    assign hrst_s = pin_s[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_d_r <= 1'b0;
            fsel_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            fsel_d_r <= fsel_s;
        end
    end

    // edges count inside a frame; a resumed frame relaunches the read bit
    assign rise = sclk_s & ~sclk_d_r & ~fsel_s;
    assign fall = ~fsel_s & ((~sclk_s & sclk_d_r) | fsel_d_r);
    assign cs_rise = fsel_s & ~fsel_d_r;

    // ----------------------------------------------------------------
    // register storage and decoded control
    // ----------------------------------------------------------------
    scp_byte_t shadow_r [0:NUM_REGS-1];
    scp_byte_t active_r [0:NUM_REGS-1];
    logic lsb_first;
    logic bidir;
    logic srst;
    logic upd;
    logic hard_rst;

    // port mode bits act straight from the buffer, without an update
    assign lsb_first = shadow_r[REG_CFG][CFG_LSB];
    assign bidir = shadow_r[REG_CFG][CFG_BIDIR];
    assign srst = shadow_r[REG_CFG][CFG_SRST];
    assign upd = shadow_r[REG_UPD][UPD_POS];
    assign hard_rst = (active_r[REG_FUNC][FUNC_POS +: 2] == FUNC_HRST)
                      & ~hrst_s;

    // ----------------------------------------------------------------
    // serial protocol engine
    // ----------------------------------------------------------------
    scp_st_e st_r;
    logic [3:0] cnt_r;
    logic [15:0] sh_r;
    logic rw_r;
    logic stream_r;
    logic [1:0] left_r;
    logic [12:0] addr_r;
    logic pend_v_r;
    logic [12:0] pend_addr_r;
    scp_byte_t pend_data_r;
    logic [15:0] sh_in;
    scp_byte_t byte_in;
    logic boundary;
    logic [12:0] addr_step;
    logic commit;

    assign sh_in = lsb_first ? {sdi_s, sh_r[15:1]} : {sh_r[14:0], sdi_s};
    assign byte_in = lsb_first ? sh_in[15:8] : sh_in[7:0];
    assign boundary = (cnt_r[2:0] == 3'h0);
    assign addr_step = lsb_first ? addr_r + 13'h0001
                                 : addr_r - 13'h0001;
    // a finished byte is stored only when the next byte starts or the
    // frame closes on a byte boundary
    assign commit = pend_v_r & boundary
                    & (cs_rise | (rise & (st_r == SCP_ST_DATA)));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= SCP_ST_INSTR;
            cnt_r <= 4'h0;
            sh_r <= 16'h0000;
            rw_r <= 1'b0;
            stream_r <= 1'b0;
            left_r <= 2'h0;
            addr_r <= 13'h0000;
            pend_v_r <= 1'b0;
            pend_addr_r <= 13'h0000;
            pend_data_r <= 8'h00;
        end else if (hard_rst) begin
            st_r <= SCP_ST_INSTR;
            cnt_r <= 4'h0;
            pend_v_r <= 1'b0;
        end else if (cs_rise) begin
            pend_v_r <= 1'b0;
            if (!boundary) begin
                st_r <= SCP_ST_INSTR;
                cnt_r <= 4'h0;
            end else if (st_r == SCP_ST_DONE
                         || (st_r == SCP_ST_DATA && stream_r)) begin
                st_r <= SCP_ST_INSTR;
                cnt_r <= 4'h0;
            end
            // otherwise a stall: all state waits for the next frame
        end else if (rise) begin
            unique case (st_r)
                SCP_ST_INSTR: begin
                    sh_r <= sh_in;
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == INSTR_LAST) begin
                        rw_r <= sh_in[INSTR_RW];
                        left_r <= sh_in[LEN_POS +: 2];
                        stream_r <= (sh_in[LEN_POS +: 2] == LEN_STREAM);
                        addr_r <= sh_in[12:0];
                        st_r <= SCP_ST_DATA;
                        cnt_r <= 4'h0;
                    end
                end
                SCP_ST_DATA: begin
                    sh_r <= sh_in;
                    cnt_r <= cnt_r + 4'h1;
                    if (boundary) begin
                        pend_v_r <= 1'b0;
                    end
                    if (cnt_r[2:0] == 3'h7) begin
                        cnt_r <= 4'h0;
                        pend_v_r <= ~rw_r;
                        pend_addr_r <= addr_r;
                        pend_data_r <= byte_in;
                        addr_r <= addr_step;
                        if (!stream_r) begin
                            if (left_r == 2'h0) begin
                                st_r <= SCP_ST_DONE;
                            end else begin
                                left_r <= left_r - 2'h1;
                            end
                        end
                    end
                end
                SCP_ST_DONE: begin
                    // surplus clocks after the announced bytes are ignored
                    cnt_r <= 4'h0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // buffer registers: serial writes, soft reset, update clear
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                shadow_r[i] <= REG_DEFAULT;
            end
        end else if (hard_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                shadow_r[i] <= REG_DEFAULT;
            end
        end else begin
            if (srst) begin
                for (int i = 1; i < NUM_REGS; i++) begin
                    shadow_r[i] <= REG_DEFAULT;
                end
            end
            if (upd) begin
                shadow_r[REG_UPD][UPD_POS] <= 1'b0;
            end
            // a serial write lands last so a new update request survives
            if (commit && pend_addr_r <= REG_LAST) begin
                shadow_r[pend_addr_r[6:0]] <= pend_data_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // active registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                active_r[i] <= REG_DEFAULT;
            end
        end else if (hard_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                active_r[i] <= REG_DEFAULT;
            end
        end else if (srst) begin
            for (int i = 1; i < NUM_REGS; i++) begin
                active_r[i] <= REG_DEFAULT;
            end
        end else if (upd) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                active_r[i] <= shadow_r[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // read data launch and line drivers
    // ----------------------------------------------------------------
    scp_byte_t rd_byte;
    logic [2:0] rd_idx;
    logic drive;
    logic out_r;
    logic out_oe_r;
    logic bidir_oe_r;

    // unused addresses above the map read as zero
    assign rd_byte = (addr_r <= REG_LAST) ? shadow_r[addr_r[6:0]]
                                          : 8'h00;
    assign rd_idx = lsb_first ? cnt_r[2:0] : 3'h7 - cnt_r[2:0];
    assign drive = ~fsel_s & (st_r == SCP_ST_DATA) & rw_r & ~hard_rst;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_r <= 1'b0;
            out_oe_r <= 1'b0;
            bidir_oe_r <= 1'b0;
        end else begin
            if (fall) begin
                out_r <= rd_byte[rd_idx];
            end
            out_oe_r <= drive & ~bidir;
            bidir_oe_r <= drive & bidir;
        end
    end

    assign link.serial_out_o = out_r;
    assign link.serial_out_oe = out_oe_r;
    assign link.dev_bidir_o = out_r;
    assign link.dev_bidir_oe = bidir_oe_r;

    // ----------------------------------------------------------------
    // user side view of the active registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_data_r <= 8'h00;
            soft_reset_r <= 1'b0;
            hard_reset_r <= 1'b0;
        end else begin
            act_data_r <= ({6'h00, act_addr} <= REG_LAST)
                          ? active_r[act_addr] : 8'h00;
            soft_reset_r <= srst;
            hard_reset_r <= hard_rst;
        end
    end
endmodule : scp_device
`default_nettype wire

// ---- verilog/scp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module scp_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata_r,
    output logic hreadyout_r,
    output logic hresp_r,
    scp_link_if.host link
);
    import scp_pkg::*;

    // ----------------------------------------------------------------
    // command registers and ahb-lite slave
    // ----------------------------------------------------------------
    scp_hst_e st_r;
    logic [15:0] instr_r;
    logic [1:0] nb_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic lsb_r;
    logic bidir_r;
    logic pause_r;
    logic done_r;
    logic pend_r;
    logic pend_wr_r;
    logic [7:0] pend_addr_r;
    logic start;

    assign start = pend_r & pend_wr_r & (pend_addr_r == HOST_CMD)
                   & (st_r == SCP_H_IDLE);

    // one wait state on every transfer; hsize is always a word here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r <= 1'b0;
            pend_wr_r <= 1'b0;
            pend_addr_r <= 8'h00;
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h0000_0000;
            hresp_r <= 1'b0;
        end else if (hsel && htrans[1] && hready) begin
            pend_r <= 1'b1;
            pend_wr_r <= hwrite;
            pend_addr_r <= haddr[7:0];
            hreadyout_r <= 1'b0;
        end else if (pend_r) begin
            pend_r <= 1'b0;
            hreadyout_r <= 1'b1;
            if (!pend_wr_r) begin
                unique case (pend_addr_r)
                    HOST_CMD: hrdata_r <= {14'h0000, nb_r, instr_r};
                    HOST_WDATA: hrdata_r <= wdata_r;
                    HOST_RDATA: hrdata_r <= rdata_r;
                    HOST_STAT: hrdata_r <= {30'h0000_0000, done_r,
                                            st_r != SCP_H_IDLE};
                    HOST_CFG: hrdata_r <= {29'h0000_0000, pause_r,
                                           bidir_r, lsb_r};
                    default: hrdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_r <= 16'h0000;
            nb_r <= 2'h0;
            wdata_r <= 32'h0000_0000;
            lsb_r <= 1'b0;
            bidir_r <= 1'b0;
            pause_r <= 1'b0;
        end else if (pend_r && pend_wr_r) begin
            // a command written while a frame runs is dropped
            if (start) begin
                instr_r <= hwdata[15:0];
                nb_r <= hwdata[17:16];
            end
            if (pend_addr_r == HOST_WDATA) begin
                wdata_r <= hwdata;
            end
            if (pend_addr_r == HOST_CFG) begin
                lsb_r <= hwdata[0];
                bidir_r <= hwdata[1];
                pause_r <= hwdata[2];
            end
        end
    end

    // ----------------------------------------------------------------
    // link engine: shift clock divider, framing, bit order
    // ----------------------------------------------------------------
    logic [1:0] in_s;
    logic [4:0] ph_r;
    logic [5:0] bit_r;
    logic [5:0] last_bit;
    logic [5:0] kdat;
    logic [4:0] didx;
    logic tx_bit;
    logic rd_phase;
    logic sdi;
    logic sclk_r;
    logic fsel_r;
    logic mo_r;
    logic mo_oe_r;

    scp_sync2 #(
        .WIDTH(2),
        .RST_VAL(2'h0)
    ) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({link.bidir_line, link.serial_out_line}),
        .q(in_s)
    );

    assign last_bit = ONE_BYTE_LAST + {1'b0, nb_r, 3'h0};
    assign kdat = bit_r - DATA_FIRST;
    assign didx = {kdat[4:3], lsb_r ? kdat[2:0] : 3'h7 - kdat[2:0]};
    assign tx_bit = (bit_r < DATA_FIRST)
                    ? instr_r[lsb_r ? bit_r[3:0] : INSTR_LAST - bit_r[3:0]]
                    : wdata_r[didx];
    assign rd_phase = instr_r[INSTR_RW] & (bit_r >= DATA_FIRST);
    assign sdi = bidir_r ? in_s[1] : in_s[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= SCP_H_IDLE;
            ph_r <= 5'h00;
            bit_r <= 6'h00;
            sclk_r <= 1'b0;
            fsel_r <= 1'b1;
            mo_r <= 1'b0;
            mo_oe_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            done_r <= 1'b0;
        end else begin
            unique case (st_r)
                SCP_H_IDLE: begin
                    if (start) begin
                        st_r <= SCP_H_SHIFT;
                        fsel_r <= 1'b0;
                        ph_r <= 5'h00;
                        bit_r <= 6'h00;
                        done_r <= 1'b0;
                    end
                end
                SCP_H_SHIFT: begin
                    ph_r <= ph_r + 5'h01;
                    if (ph_r == 5'h00) begin
                        sclk_r <= 1'b0;
                        mo_r <= tx_bit;
                        mo_oe_r <= ~(rd_phase & bidir_r);
                    end
                    if (ph_r == SCLK_HALF) begin
                        sclk_r <= 1'b1;
                        if (rd_phase) begin
                            rdata_r[didx] <= sdi;
                        end
                    end
                    if (ph_r == SCLK_LAST) begin
                        ph_r <= 5'h00;
                        bit_r <= bit_r + 6'h01;
                        if (bit_r == last_bit) begin
                            st_r <= SCP_H_GAP;
                            fsel_r <= 1'b1;
                            sclk_r <= 1'b0;
                            mo_oe_r <= 1'b0;
                        end else if (pause_r && bit_r[2:0] == 3'h7
                                     && instr_r[LEN_POS +: 2]
                                        != LEN_STREAM) begin
                            st_r <= SCP_H_PAUSE;
                            fsel_r <= 1'b1;
                            sclk_r <= 1'b0;
                        end
                    end
                end
                SCP_H_PAUSE: begin
                    ph_r <= ph_r + 5'h01;
                    if (ph_r == SCLK_LAST) begin
                        ph_r <= 5'h00;
                        fsel_r <= 1'b0;
                        st_r <= SCP_H_SHIFT;
                    end
                end
                SCP_H_GAP: begin
                    ph_r <= ph_r + 5'h01;
                    if (ph_r == SCLK_LAST) begin
                        ph_r <= 5'h00;
                        st_r <= SCP_H_IDLE;
                        done_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign link.sclk = sclk_r;
    assign link.frame_select_n = fsel_r;
    assign link.host_bidir_o = mo_r;
    assign link.host_bidir_oe = mo_oe_r;
endmodule : scp_host
`default_nettype wire

// ---- tb/scp_link_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module scp_link_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sclk,
    input wire logic frame_select_n,
    input wire logic host_bidir_o,
    input wire logic host_bidir_oe,
    input wire logic dev_bidir_o,
    input wire logic dev_bidir_oe,
    input wire logic serial_out_o,
    input wire logic serial_out_oe
);
    logic sclk_r;
    logic [2:0] rise_cnt_r;
    // rises are never cleared by a pause, so whole bytes keep it at zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_r <= 1'b0;
            rise_cnt_r <= 3'h0;
        end else begin
            sclk_r <= sclk;
            rise_cnt_r <= rise_cnt_r + {2'h0, sclk && !sclk_r};
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    one_driver_a: assert property (!(serial_out_oe && dev_bidir_oe))
        else $error("two read drivers");
    idle_release_a: assert property (frame_select_n [*5] |->
        !serial_out_oe && !dev_bidir_oe) else $error("driven while idle");
    idle_clock_a: assert property (frame_select_n |-> !sclk)
        else $error("clock outside frame");
    host_launch_a: assert property (host_bidir_oe &&
        $changed(host_bidir_o) |-> !sclk) else $error("host data late");
    out_launch_a: assert property (serial_out_oe && $past(serial_out_oe)
        && $changed(serial_out_o) |-> !sclk) else $error("out bit late");
    bidir_launch_a: assert property (dev_bidir_oe && $past(dev_bidir_oe)
        && $changed(dev_bidir_o) |-> !sclk) else $error("bidir bit late");
    read_frame_a: assert property ($rose(serial_out_oe)
        || $rose(dev_bidir_oe) |-> !frame_select_n) else $error("oe no frame");
    clock_high_a: assert property ($rose(sclk) |-> sclk [*4])
        else $error("short clock high");
    byte_bound_a: assert property ($rose(frame_select_n)
        |-> rise_cnt_r == 3'h0) else $error("raise off byte");
    cover property ($rose(serial_out_oe));
    cover property ($rose(dev_bidir_oe));
    cover property ($rose(frame_select_n) ##[1:20] $fell(frame_select_n));
endmodule : scp_link_asserts
`default_nettype wire

// ---- tb/serial_config_port_reset_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_config_port_reset_test;
    import scp_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hard_reset_n = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic [6:0] act_addr = 7'h00;
    scp_byte_t act_data;
    logic soft_rst;
    logic hard_rst;
    logic [31:0] q;
    logic [6:0] a;
    logic [7:0] b0;
    logic [7:0] b1;
    int num_errors = 0;
    int samples_checked = 0;
    scp_link_if link_i ();
    scp_host scp_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata_r(hrdata),
        .hreadyout_r(hready), .hresp_r(), .link(link_i.host));
    scp_device scp_device_i (.hclk(hclk), .hresetn(hresetn),
        .link(link_i.device), .hard_reset_n(hard_reset_n),
        .act_addr(act_addr), .act_data_r(act_data),
        .soft_reset_r(soft_rst), .hard_reset_r(hard_rst));
    scp_link_asserts scp_link_asserts_i (.hclk(hclk), .hresetn(hresetn),
        .sclk(link_i.sclk), .frame_select_n(link_i.frame_select_n),
        .host_bidir_o(link_i.host_bidir_o),
        .host_bidir_oe(link_i.host_bidir_oe),
        .dev_bidir_o(link_i.dev_bidir_o), .dev_bidir_oe(link_i.dev_bidir_oe),
        .serial_out_o(link_i.serial_out_o),
        .serial_out_oe(link_i.serial_out_oe));
    always #20 hclk = ~hclk;
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] ad,
        input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    // one whole frame through the host; q ends with the read bytes
    task automatic frame(input logic rd, input logic [1:0] len,
        input logic [6:0] ad, input logic [1:0] nb, input logic [31:0] d);
        bus(1'b1, HOST_WDATA, d);
        bus(1'b1, HOST_CMD, {14'h0, nb, rd, len, 6'h0, ad});
        q = 32'h0;
        while (q[1] !== 1'b1) bus(1'b0, HOST_STAT, 32'h0);
        bus(1'b0, HOST_RDATA, 32'h0);
    endtask : frame
    task automatic wr(input logic [6:0] ad, input logic [7:0] v);
        frame(1'b0, 2'h0, ad, 2'h0, {24'h0, v});
    endtask : wr
    task automatic act(input logic [6:0] ad, input scp_byte_t v);
        act_addr <= ad;
        repeat (2) @(posedge hclk);
        chk({24'h0, act_data}, {24'h0, v});
    endtask : act
    function automatic logic [6:0] step(input logic [6:0] ad, input logic up);
        return up ? ad + 7'h01 : ad - 7'h01;
    endfunction : step
    initial begin
        repeat (80000) @(posedge hclk);
        num_errors++;
        final_report;
    end
    initial begin
        void'($urandom(32'h0EC3));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        a = 7'($urandom_range(4, 80));
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        act(a, 8'h00);
        bus(1'b1, HOST_CFG, 32'h4);
        frame(1'b0, 2'h1, a, 2'h1, {16'h0, b1, b0});
        frame(1'b1, 2'h0, a - 7'h01, 2'h0, 32'h0);
        chk(q, {24'h0, b1});
        act(a, 8'h00);
        wr(REG_UPD, 8'h01);
        act(a, b0);
        frame(1'b1, 2'h0, REG_UPD, 2'h0, 32'h0);
        chk(q, 32'h0);
        // host does not track the mode bits, so CFG follows each change
        for (int k = 1; k < 4; k++) begin
            wr(REG_CFG, {k[1], k[0], 6'h0});
            bus(1'b1, HOST_CFG, {29'h0, 1'b1, k[1], k[0]});
            frame(1'b0, 2'h3, a, 2'h3, {b1, b0, b1, b0});
            frame(1'b1, 2'h0, step(step(a, k[0]), k[0]), 2'h0, 32'h0);
            chk(q, {24'h0, b0});
        end
        wr(REG_CFG, 8'hE0);
        chk({31'h0, soft_rst}, 32'h1);
        frame(1'b1, 2'h0, a, 2'h0, 32'h0);
        chk(q, 32'h0);
        frame(1'b1, 2'h0, REG_CFG, 2'h0, 32'h0);
        chk(q, 32'h000000E0);
        wr(REG_CFG, 8'hC0);
        chk({31'h0, soft_rst}, 32'h0);
        wr(a, b1);
        hard_reset_n <= 1'b0;
        repeat (6) @(posedge hclk);
        chk({31'h0, hard_rst}, 32'h1);
        hard_reset_n <= 1'b1;
        repeat (6) @(posedge hclk);
        bus(1'b1, HOST_CFG, 32'h0);
        frame(1'b1, 2'h0, a, 2'h0, 32'h0);
        chk(q, 32'h0);
        final_report;
    end
endmodule : serial_config_port_reset_test
`default_nettype wire
